// >>> hdl/adcat_pkg.sv
// Constants shared by the acquisition timing configuration block.
// Assumes an 8-bit register port and a single system clock.
//
// Contract
// R01 - Nonzero acquisition field gives N converter cycles.
// R02 - Zero acquisition with precharge gives 256 cycles.
// R03 - Capacitor field bits 4..0, upper bits read zero.
// R04 - Extra capacitance equals field value in picofarads.
// R05 - Oscillator source counts undivided, ignoring divider.
// R06 - Repeat threshold with counter decides threshold check.
// R07 - All fields reset to zero, software read/write.
package adcat_pkg;

    // Register indices on the 8-bit register port.
    localparam logic [7:0] ADDR_ACQ = 8'h00;
    localparam logic [7:0] ADDR_CAP = 8'h01;
    localparam logic [7:0] ADDR_RPT = 8'h02;
    localparam logic [7:0] ADDR_PRE = 8'h03;
    localparam logic [7:0] ADDR_CLKSEL = 8'h04;
    localparam logic [7:0] ADDR_DIV = 8'h05;
    localparam logic [7:0] ADDR_MODE = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h07;
    localparam logic [7:0] ADDR_COUNT = 8'h08;

    // Reset values.
    localparam logic [7:0] RST_ACQ = 8'h00;
    localparam logic [4:0] RST_CAP = 5'h00;
    localparam logic [7:0] RST_RPT = 8'h00;
    localparam logic [7:0] RST_PRE = 8'h00;
    localparam logic RST_CLKSEL = 1'b0;
    localparam logic [5:0] RST_DIV = 6'h00;
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [7:0] RST_COUNT = 8'h00;

    // Field widths and positions.
    localparam int CAP_W = 5;
    localparam int DIV_W = 6;
    localparam int MODE_W = 3;
    localparam int LEN_W = 9;
    localparam int CLKSEL_BIT = 0;

    // Window used when the acquisition field is zero and precharge is set.
    localparam logic [8:0] ACQ_LONG_LEN = 9'h100;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    typedef enum logic [2:0] {
        MODE_BASIC = 3'b000,
        MODE_ACCUM = 3'b001,
        MODE_AVG = 3'b010,
        MODE_BURST = 3'b011,
        MODE_LPF = 3'b100
    } adcat_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PRECH = 2'b01,
        ST_ACQ = 2'b10,
        ST_CONV = 2'b11
    } adcat_state_t;

    // Acquisition window in converter clock cycles.
    function automatic logic [8:0] acq_len(input logic [7:0] acq, input logic [7:0] pre);
        if (acq != 8'h00) begin
            acq_len = {1'b0, acq};
        end else if (pre != 8'h00) begin
            acq_len = ACQ_LONG_LEN;
        end else begin
            acq_len = 9'h000;
        end
    endfunction

endpackage

// >>> hdl/adcat_tick_counter.sv
// Down counter that times one phase in converter clock ticks.
// Assumes the tick strobe is a one-cycle enable in the CLK domain.
`timescale 1ns/1ps
`default_nettype none
module adcat_tick_counter (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Control.
    input wire logic load,
    input wire logic [8:0] len,
    input wire logic tick,
    // Status.
    output logic busy,
    output logic done
);

    logic [8:0] count_r;
    logic [8:0] count_nxt;
    logic last_tick;

    assign busy = count_r != 9'h000;
    assign last_tick = busy && tick && (count_r == 9'h001);
    assign done = last_tick;

    // A load wins over the running count so the next phase starts seamlessly.
    assign count_nxt = load ? len :
                       (busy && tick) ? count_r - 9'h001 : count_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= 9'h000;
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> hdl/adcat_top.sv
// Acquisition timing configuration and sample phase sequencing.
// Assumes synchronous inputs on CLK, which is the system oscillator.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adcat_top (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESETN,
    // Register port.
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Conversion sequencer.
    input wire logic TRIGGER,
    input wire logic CONV_DONE,
    output logic PRECHARGE_ON,
    output logic SAMPLE_ON,
    output logic CONV_START,
    output logic THRESH_CHECK,
    // Analogue sample circuit.
    output logic [4:0] CAP_SELECT
);

    // Software registers.
    logic [7:0] acq_time_field_r;
    logic [4:0] extra_cap_field_r;
    logic [7:0] repeat_threshold_field_r;
    logic [7:0] precharge_time_field_r;
    logic clk_osc_sel_r;
    logic [5:0] converter_clock_divider_r;
    logic [2:0] mode_r;
    logic [7:0] conversion_counter_r;
    logic [7:0] conversion_counter_nxt;

    // Register port decode.
    logic wr_acq;
    logic wr_cap;
    logic wr_rpt;
    logic wr_pre;
    logic wr_clksel;
    logic wr_div;
    logic wr_mode;
    logic wr_count;
    logic [7:0] rd_mux;
    logic [7:0] rdata_r;
    logic [7:0] status_word;
    logic hit_acq;
    logic hit_cap;
    logic hit_rpt;
    logic hit_pre;
    logic hit_clksel;
    logic hit_div;
    logic hit_mode;
    logic hit_status;
    logic hit_count;

    // Converter clock tick generation.
    logic [5:0] div_cnt_r;
    logic [5:0] div_cnt_nxt;
    logic div_wrap;
    logic adc_tick;

    // Sequencer.
    adcat_pkg::adcat_state_t state_r;
    adcat_pkg::adcat_state_t state_nxt;
    logic [8:0] acq_window;
    logic [8:0] pre_window;
    logic start_ok;
    logic load_timer;
    logic [8:0] load_len;
    logic timer_busy;
    logic timer_done;
    logic conv_start_r;
    logic conv_start_nxt;
    logic thresh_r;
    logic thresh_nxt;
    logic check_mode;
    logic count_reached;

    // One address match per register, shared by the write and read paths.
    assign hit_acq = REG_ADDR == adcat_pkg::ADDR_ACQ;
    assign hit_cap = REG_ADDR == adcat_pkg::ADDR_CAP;
    assign hit_rpt = REG_ADDR == adcat_pkg::ADDR_RPT;
    assign hit_pre = REG_ADDR == adcat_pkg::ADDR_PRE;
    assign hit_clksel = REG_ADDR == adcat_pkg::ADDR_CLKSEL;
    assign hit_div = REG_ADDR == adcat_pkg::ADDR_DIV;
    assign hit_mode = REG_ADDR == adcat_pkg::ADDR_MODE;
    assign hit_status = REG_ADDR == adcat_pkg::ADDR_STATUS;
    assign hit_count = REG_ADDR == adcat_pkg::ADDR_COUNT;

    // Address decode for writes; the status word has no write strobe.
    assign wr_acq = REG_WR && hit_acq;
    assign wr_cap = REG_WR && hit_cap;
    assign wr_rpt = REG_WR && hit_rpt;
    assign wr_pre = REG_WR && hit_pre;
    assign wr_clksel = REG_WR && hit_clksel;
    assign wr_div = REG_WR && hit_div;
    assign wr_mode = REG_WR && hit_mode;
    assign wr_count = REG_WR && hit_count;

    assign status_word = {5'h00, state_r, timer_busy};

    // Read selection; unmapped addresses and unimplemented bits read zero.
    assign rd_mux =
        hit_acq ? acq_time_field_r :
        hit_cap ? {3'h0, extra_cap_field_r} : // R03
        hit_rpt ? repeat_threshold_field_r :
        hit_pre ? precharge_time_field_r :
        hit_clksel ? {7'h00, clk_osc_sel_r} :
        hit_div ? {2'h0, converter_clock_divider_r} :
        hit_mode ? {5'h00, mode_r} :
        hit_status ? status_word :
        hit_count ? conversion_counter_r : 8'h00;

    // Read data stands only in the cycle after the read strobe.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= REG_RD ? rd_mux : 8'h00;
        end
    end

    assign REG_RDATA = rdata_r;

    // Configuration registers, all cleared by reset.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            acq_time_field_r <= adcat_pkg::RST_ACQ; // R07
            extra_cap_field_r <= adcat_pkg::RST_CAP; // R07
            repeat_threshold_field_r <= adcat_pkg::RST_RPT; // R07
            precharge_time_field_r <= adcat_pkg::RST_PRE;
        end else begin
            if (wr_acq) begin
                acq_time_field_r <= REG_WDATA; // R07
            end
            if (wr_cap) begin
                extra_cap_field_r <= REG_WDATA[4:0]; // R03
            end
            if (wr_rpt) begin
                repeat_threshold_field_r <= REG_WDATA; // R07
            end
            if (wr_pre) begin
                precharge_time_field_r <= REG_WDATA;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            clk_osc_sel_r <= adcat_pkg::RST_CLKSEL;
            converter_clock_divider_r <= adcat_pkg::RST_DIV;
            mode_r <= adcat_pkg::RST_MODE;
        end else begin
            if (wr_clksel) begin
                clk_osc_sel_r <= REG_WDATA[adcat_pkg::CLKSEL_BIT];
            end
            if (wr_div) begin
                converter_clock_divider_r <= REG_WDATA[5:0];
            end
            if (wr_mode) begin
                mode_r <= REG_WDATA[2:0];
            end
        end
    end

    // The capacitor code drives the switch bank directly, one pF per LSB.
    assign CAP_SELECT = extra_cap_field_r; // R04

    // Divided converter clock: one tick every 2*(divider bits 4..0 + 1) system cycles; divider bit 5 is ignored.
    assign div_wrap = div_cnt_r >= {converter_clock_divider_r[4:0], 1'b1};
    assign div_cnt_nxt = div_wrap ? 6'h00 : div_cnt_r + 6'h01;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            div_cnt_r <= 6'h00;
        end else begin
            div_cnt_r <= div_cnt_nxt;
        end
    end

    // The oscillator source ticks every cycle and ignores the divider.
    assign adc_tick = clk_osc_sel_r ? 1'b1 : div_wrap; // R05

    // Phase lengths in converter cycles.
    assign acq_window = adcat_pkg::acq_len(acq_time_field_r, precharge_time_field_r); // R01 R02
    assign pre_window = {1'b0, precharge_time_field_r};

    // Only a trigger taken in idle counts; one that arrives mid-conversion is dropped.
    assign start_ok = TRIGGER && (state_r == adcat_pkg::ST_IDLE);

    // Next state and timer load; a zero-length phase is skipped.
    always_comb begin
        state_nxt = state_r;
        load_timer = 1'b0;
        load_len = 9'h000;
        conv_start_nxt = 1'b0;
        case (state_r)
            adcat_pkg::ST_IDLE: begin
                if (TRIGGER) begin
                    if (pre_window != 9'h000) begin
                        state_nxt = adcat_pkg::ST_PRECH;
                        load_timer = 1'b1;
                        load_len = pre_window;
                    end else if (acq_window != 9'h000) begin
                        state_nxt = adcat_pkg::ST_ACQ;
                        load_timer = 1'b1;
                        load_len = acq_window; // R01
                    end else begin
                        state_nxt = adcat_pkg::ST_CONV;
                        conv_start_nxt = 1'b1;
                    end
                end
            end
            adcat_pkg::ST_PRECH: begin
                if (timer_done) begin
                    state_nxt = adcat_pkg::ST_ACQ;
                    load_timer = 1'b1;
                    load_len = acq_window; // R02
                end
            end
            adcat_pkg::ST_ACQ: begin
                if (timer_done) begin
                    state_nxt = adcat_pkg::ST_CONV;
                    conv_start_nxt = 1'b1;
                end
            end
            adcat_pkg::ST_CONV: begin
                if (CONV_DONE) begin
                    state_nxt = adcat_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = adcat_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_r <= adcat_pkg::ST_IDLE;
            conv_start_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            conv_start_r <= conv_start_nxt;
        end
    end

    // One shared timer serves both phases; it is reloaded at each phase boundary.
    adcat_tick_counter u_phase_timer (
        .clk(CLK),
        .resetn(RESETN),
        .load(load_timer),
        .len(load_len),
        .tick(adc_tick),
        .busy(timer_busy),
        .done(timer_done)
    );

    assign PRECHARGE_ON = state_r == adcat_pkg::ST_PRECH;
    assign SAMPLE_ON = state_r == adcat_pkg::ST_ACQ; // R01
    assign CONV_START = conv_start_r;

    // Trigger counter saturates; a trigger in the cycle of a clearing write still counts.
    always_comb begin
        conversion_counter_nxt = conversion_counter_r;
        if (wr_count) begin
            conversion_counter_nxt = adcat_pkg::RST_COUNT;
        end
        if (start_ok && (conversion_counter_nxt != adcat_pkg::COUNT_MAX)) begin
            conversion_counter_nxt = conversion_counter_nxt + 8'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            conversion_counter_r <= adcat_pkg::RST_COUNT;
        end else begin
            conversion_counter_r <= conversion_counter_nxt;
        end
    end

    // Threshold is checked only in the averaging, burst and filter modes.
    assign check_mode = (mode_r == adcat_pkg::MODE_AVG) ||
                        (mode_r == adcat_pkg::MODE_BURST) ||
                        (mode_r == adcat_pkg::MODE_LPF);
    assign count_reached = conversion_counter_r >= repeat_threshold_field_r; // R06
    assign thresh_nxt = CONV_DONE && (state_r == adcat_pkg::ST_CONV) &&
                        check_mode && count_reached; // R06

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            thresh_r <= 1'b0;
        end else begin
            thresh_r <= thresh_nxt;
        end
    end

    assign THRESH_CHECK = thresh_r;

endmodule
`default_nettype wire

// >>> tb/adcat_seq_model.sv
// Behavioural model of the conversion sequencer beside the block.
// Assumes the block pulses conversion start for one cycle.
`timescale 1ns/1ps
`default_nettype none
module adcat_seq_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Handshake with the block.
    input wire logic conv_start,
    input wire logic [3:0] lag,
    output logic conv_done
);
    logic [3:0] cnt_r;
    logic busy_r;

    // The finish pulse comes lag+2 cycles after the start pulse, so slow converters are covered too.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= busy_r && cnt_r == 4'h0;
            if (conv_start) begin
                busy_r <= 1'b1;
                cnt_r <= lag;
            end else if (busy_r) begin
                busy_r <= cnt_r != 4'h0;
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/adcat_tb_top.sv
// Self-checking bench for the acquisition timing block.
// Assumes the package, the block and the sequencer model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adcat_tb_top;
    logic clk, resetn, wr_s, rd_s, trig, done, pre_on, smp_on, start, thr;
    logic [7:0] addr, wdata, rdata;
    logic [4:0] cap_sel;
    logic [3:0] lag;
    int fail_count = 0;
    int samples_checked = 0;

    adcat_top DUT (.CLK(clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .TRIGGER(trig), .CONV_DONE(done),
        .PRECHARGE_ON(pre_on), .SAMPLE_ON(smp_on), .CONV_START(start), .THRESH_CHECK(thr),
        .CAP_SELECT(cap_sel));
    adcat_seq_model u_seq (.clk(clk), .resetn(resetn), .conv_start(start), .lag(lag),
        .conv_done(done));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask

    // One triggered conversion; counts each phase until the cycle after the finish pulse.
    task automatic run(input logic [7:0] p, input logic [7:0] a, input logic [8:0] w,
            input logic th_exp);
        int np, ns, nc;
        logic th, dn;
        np = 0;
        ns = 0;
        nc = 0;
        th = 1'b0;
        dn = 1'b0;
        wr(adcat_pkg::ADDR_PRE, p);
        wr(adcat_pkg::ADDR_ACQ, a);
        trig <= 1'b1;
        for (int k = 0; k < 600; k++) begin
            @(posedge clk);
            trig <= 1'b0;
            #1;
            np += pre_on;
            ns += smp_on;
            nc += start;
            th |= thr;
            if (dn) break;
            dn = done;
        end
        chk(9'(np), {1'b0, p});
        chk(9'(ns), w);
        chk(9'(nc), 9'h001);
        chk(9'(th), 9'(th_exp));
    endtask

    task automatic t_regs();
        logic [7:0] v;
        wr(adcat_pkg::ADDR_ACQ, 8'hff);
        wr(adcat_pkg::ADDR_CAP, 8'hff);
        wr(adcat_pkg::ADDR_RPT, 8'ha5);
        wr(8'h40, 8'h5a);
        rd(adcat_pkg::ADDR_ACQ, v);
        chk(9'(v), 9'h0ff);
        rd(adcat_pkg::ADDR_CAP, v);
        chk(9'(v), 9'h01f);
        chk(9'(cap_sel), 9'h01f);
        rd(adcat_pkg::ADDR_RPT, v);
        chk(9'(v), 9'h0a5);
        rd(8'h40, v);
        chk(9'(v), 9'h000);
        wr(adcat_pkg::ADDR_CAP, 8'h1e);
        rd(adcat_pkg::ADDR_CAP, v);
        chk(9'(v), 9'h01e);
        chk(9'(cap_sel), 9'h01e);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            rd(8'(i), v);
            chk(9'(v), 9'h000);
        end
        chk(9'(cap_sel), 9'h000);
        $display("register test finished");
    endtask

    task automatic t_windows();
        wr(adcat_pkg::ADDR_CLKSEL, 8'h01);
        wr(adcat_pkg::ADDR_DIV, 8'h1f);
        run(8'h00, 8'h01, 9'h001, 1'b0);
        lag <= 4'h9;
        run(8'h00, 8'hff, 9'h0ff, 1'b0);
        run(8'h02, 8'h00, 9'h100, 1'b0);
        run(8'h03, 8'h05, 9'h005, 1'b0);
        run(8'h00, 8'h00, 9'h000, 1'b0);
        $display("window test finished");
    endtask

    task automatic t_thresh();
        for (int m = 0; m < 5; m++) begin
            wr(adcat_pkg::ADDR_COUNT, 8'h00);
            wr(adcat_pkg::ADDR_RPT, 8'h02);
            wr(adcat_pkg::ADDR_MODE, 8'(m));
            run(8'h00, 8'h03, 9'h003, 1'b0);
            run(8'h00, 8'h03, 9'h003, m >= 2);
        end
        $display("threshold test finished");
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_s = 1'b0;
        rd_s = 1'b0;
        trig = 1'b0;
        lag = 4'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_windows();
        t_thresh();
        tally_and_finish();
    end

    initial begin
        #200000;
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> tb/adcat_top_chk.sv
// Checker for the acquisition timing block, bound to its top module.
// Assumes window lengths are judged only with the undivided source.
`timescale 1ns/1ps
`default_nettype none
module adcat_top_chk (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RESETN,
    // Register port.
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Sequencer and sample circuit.
    input wire logic CONV_DONE,
    input wire logic PRECHARGE_ON,
    input wire logic SAMPLE_ON,
    input wire logic CONV_START,
    input wire logic THRESH_CHECK,
    input wire logic [4:0] CAP_SELECT
);
    logic [7:0] sh_r [0:6];
    logic [1:0] ph_r;
    logic [8:0] run_r;
    wire [1:0] ph = {PRECHARGE_ON, SAMPLE_ON};
    wire [7:0] acq = sh_r[0];
    wire [7:0] cap = sh_r[1];
    wire osc = sh_r[4][0];
    wire [2:0] mode = sh_r[6][2:0];
    wire [8:0] win = (acq != 8'h00) ? {1'b0, acq} : 9'h100;

    // Shadows of the written settings, and the length of the current phase.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < 7; i++) sh_r[i] <= 8'h00;
            ph_r <= 2'b00;
            run_r <= 9'h000;
        end else begin
            if (REG_WR && REG_ADDR < 8'h07) sh_r[REG_ADDR[2:0]] <= REG_WDATA;
            ph_r <= ph;
            run_r <= (ph == ph_r) ? run_r + 9'h001 : 9'h001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    a_acq_window: assert property ($past(RESETN) && $fell(SAMPLE_ON) && osc |-> run_r == win)
        else $error("sample window length wrong");
    a_conv_after: assert property ($past(RESETN) && $fell(SAMPLE_ON) |-> CONV_START ##1 !CONV_START)
        else $error("conversion start not one cycle after window");
    a_prech_window: assert property ($past(RESETN) && $fell(PRECHARGE_ON) && osc |-> run_r == {1'b0, sh_r[3]})
        else $error("precharge length wrong");
    a_cap_upper: assert property (REG_RD && REG_ADDR == adcat_pkg::ADDR_CAP |=> REG_RDATA == ($past(cap) & 8'h1f))
        else $error("capacitor readback wrong");
    a_cap_follows: assert property ({3'h0, CAP_SELECT} == (cap & 8'h1f))
        else $error("capacitor select differs from setting");
    a_thresh_cause: assert property (THRESH_CHECK |-> $past(CONV_DONE) && $past(mode) inside {3'h2, 3'h3, 3'h4})
        else $error("threshold check without cause");
    a_acq_readback: assert property (REG_RD && REG_ADDR == adcat_pkg::ADDR_ACQ |=> REG_RDATA == $past(acq))
        else $error("acquisition readback wrong");
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside the read answer cycle");

    cover property ($fell(SAMPLE_ON) && run_r == 9'h100);
    cover property ($fell(PRECHARGE_ON) && SAMPLE_ON);
    cover property (THRESH_CHECK);
endmodule

bind adcat_top adcat_top_chk u_chk (.CLK(CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CONV_DONE(CONV_DONE), .PRECHARGE_ON(PRECHARGE_ON), .SAMPLE_ON(SAMPLE_ON),
    .CONV_START(CONV_START), .THRESH_CHECK(THRESH_CHECK), .CAP_SELECT(CAP_SELECT));
`default_nettype wire
